// >>> verilog/ofd_defines.svh
`ifndef OFD_DEFINES_SVH
`define OFD_DEFINES_SVH

// ----------------------------------------
// Field positions in the addressing byte
// ----------------------------------------
`define OFD_FORM_HI 7
`define OFD_FORM_LO 6
`define OFD_RM_HI 2
`define OFD_RM_LO 0

// ----------------------------------------
// Addressing form codes
// ----------------------------------------
`define OFD_FORM_NODISP 2'h0
`define OFD_FORM_DISP8 2'h1
`define OFD_FORM_DISPW 2'h2
`define OFD_FORM_REG 2'h3

// ----------------------------------------
// Register/memory codes with special meaning
// ----------------------------------------
`define OFD_RM16_DIRECT 3'h6
`define OFD_RM32_SIB 3'h4
`define OFD_RM32_DIRECT 3'h5

// ----------------------------------------
// Reset values of the decoded outputs
// ----------------------------------------
`define OFD_RST_LEN 3'h0
`define OFD_RST_IMM 32'h0

`endif

// >>> verilog/ofd_pkg.sv
package ofd_pkg;

  // Operand size as seen by the decoder
  typedef enum logic [1:0] {
    OFD_SZ8 = 2'h0,
    OFD_SZ16 = 2'h1,
    OFD_SZ32 = 2'h2
  } ofd_size_t;

  // Class of system register implied by the opcode
  typedef enum logic [1:0] {
    OFD_CLS_NONE = 2'h0,
    OFD_CLS_CTRL = 2'h1,
    OFD_CLS_DBG = 2'h2,
    OFD_CLS_TEST = 2'h3
  } ofd_class_t;

  // Base register of a memory operand
  typedef enum logic [3:0] {
    OFD_BASE_NONE = 4'h0,
    OFD_BASE_BX_SI = 4'h1,
    OFD_BASE_BX_DI = 4'h2,
    OFD_BASE_BP_SI = 4'h3,
    OFD_BASE_BP_DI = 4'h4,
    OFD_BASE_SI = 4'h5,
    OFD_BASE_DI = 4'h6,
    OFD_BASE_BP = 4'h7,
    OFD_BASE_BX = 4'h8,
    OFD_BASE_GPR32 = 4'h9,
    OFD_BASE_SIB = 4'ha
  } ofd_base_t;

  // Segment used by a memory operand
  typedef enum logic {
    OFD_SEG_DATA = 1'b0,
    OFD_SEG_STACK = 1'b1
  } ofd_seg_t;

  // Register operand width
  typedef enum logic [1:0] {
    OFD_RW_LOW8 = 2'h0,
    OFD_RW_HIGH8 = 2'h1,
    OFD_RW_16 = 2'h2,
    OFD_RW_32 = 2'h3
  } ofd_regw_t;

endpackage

// >>> verilog/ofd_imm_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module ofd_imm_decoder (
  input wire logic sext_bit_in,
  input wire ofd_pkg::ofd_size_t op_size_in,
  input wire logic [31:0] imm_raw_in,
  output logic [2:0] imm_len_out,
  output logic [31:0] imm_value_out
);
  import ofd_pkg::*;

  // ----------------------------------------
  // Immediate length and extension
  // ----------------------------------------
  wire logic byte_imm;
  wire logic [31:0] sext_byte;
  wire logic [31:0] sext_half;

  // Single byte for byte operands or when the sign-extend bit is set
  assign byte_imm = (op_size_in == OFD_SZ8) || sext_bit_in; // RL1 RL2
  assign sext_byte = {{24{imm_raw_in[7]}}, imm_raw_in[7:0]}; // RL1
  assign sext_half = {16'h0, imm_raw_in[15:0]};

  // Length in bytes and value
  assign imm_len_out = byte_imm ? 3'h1 : (op_size_in == OFD_SZ16) ? 3'h2 : 3'h4; // RL2
  assign imm_value_out = (op_size_in == OFD_SZ8) ? {24'h0, imm_raw_in[7:0]} :
                         sext_bit_in ? sext_byte :
                         (op_size_in == OFD_SZ16) ? sext_half : imm_raw_in; // RL1 RL2

endmodule

`default_nettype wire

// >>> verilog/ofd_operand_decoder.sv
// How it works
// RL1: Sign-extend bit with 16/32-bit operand takes one byte, sign-extended.
// RL2: Otherwise immediate length equals operand size; byte operands always one byte.
// RL3: System-register moves pick register from selector plus opcode class.
// RL4: Control class: codes 000, 010, 011, 100 pick registers 0, 2, 3, 4.
// RL5: Debug class: codes 000-011 pick 0-3, codes 110/111 pick 6/7.
// RL6: Test class: codes 011-111 pick 3-7; other codes are not valid.
// RL7: Unlisted selector code raises invalid-instruction instead of any access.
// RL8: Form and r/m fields pick addressing; fixed-mode opcodes expect no byte.
// RL9: 16-bit form 00 uses base/index pairs; code 110 is direct address.
// RL10: 16-bit forms 01/10 add byte/halfword displacement; 110 is base pointer, stack segment.
// RL11: 32-bit memory forms with code 100 expect a scaled-index byte.
// RL12: 32-bit code picks base; 00-101 direct; 01/10 add displacement, 101 stack.
// RL13: Form 11 is a register operand from code, width bit and size.
// RL14: Width 0 picks low/high bytes of regs 0-3; width 1 full regs.
// RL15: Width bit 0 means byte; 1 means 16 or 32 bits by mode.
`timescale 1ns/1ps
`default_nettype none
`include "ofd_defines.svh"

module ofd_operand_decoder (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire logic has_modrm_in,
  input wire logic addr32_in,
  input wire logic op32_in,
  input wire logic width_bit_in,
  input wire logic width_present_in,
  input wire logic sext_bit_in,
  input wire logic [7:0] modrm_in,
  input wire logic [31:0] imm_raw_in,
  input wire ofd_pkg::ofd_class_t sys_class_in,
  input wire logic [2:0] sys_sel_in,
  output logic valid_out,
  output logic is_mem_out,
  output logic is_reg_out,
  output logic need_sib_out,
  output logic [2:0] disp_len_out,
  output ofd_pkg::ofd_base_t base_out,
  output logic [2:0] base_gpr_out,
  output ofd_pkg::ofd_seg_t seg_out,
  output logic [2:0] reg_num_out,
  output ofd_pkg::ofd_regw_t reg_width_out,
  output ofd_pkg::ofd_size_t op_size_out,
  output logic [2:0] imm_len_out,
  output logic [31:0] imm_value_out,
  output logic sys_valid_out,
  output logic [2:0] sys_reg_out,
  output logic invalid_out
);
  import ofd_pkg::*;

  // ----------------------------------------
  // Field extraction and operand size
  // ----------------------------------------
  wire logic [1:0] form;
  wire logic [2:0] rm;
  wire ofd_size_t op_size;
  wire logic reg_form;

  assign form = modrm_in[`OFD_FORM_HI:`OFD_FORM_LO]; // RL8
  assign rm = modrm_in[`OFD_RM_HI:`OFD_RM_LO]; // RL8
  // Absent width bit means full width
  assign op_size = (width_present_in && !width_bit_in) ? OFD_SZ8 :
                   op32_in ? OFD_SZ32 : OFD_SZ16; // RL15
  assign reg_form = has_modrm_in && (form == `OFD_FORM_REG); // RL13

  // ----------------------------------------
  // System register selector check
  // ----------------------------------------
  // Valid selector codes for each register class
  function automatic logic sel_ok(input ofd_class_t cls, input logic [2:0] sel);
    case (cls)
      OFD_CLS_CTRL: sel_ok = (sel == 3'h0) || (sel == 3'h2) || (sel == 3'h3) ||
                             (sel == 3'h4); // RL4
      OFD_CLS_DBG: sel_ok = (sel != 3'h4) && (sel != 3'h5); // RL5
      OFD_CLS_TEST: sel_ok = (sel >= 3'h3); // RL6
      default: sel_ok = 1'b1;
    endcase
  endfunction

  wire logic sys_access;
  wire logic sys_good;

  assign sys_access = (sys_class_in != OFD_CLS_NONE); // RL3
  assign sys_good = sel_ok(sys_class_in, sys_sel_in); // RL3

  // ----------------------------------------
  // 16-bit addressing decode
  // ----------------------------------------
  // Base/index pair (codes 000-011) or single base register (codes 100-111) for each 16-bit r/m code
  function automatic ofd_base_t base16(input logic [2:0] code);
    case (code)
      3'h0: base16 = OFD_BASE_BX_SI;
      3'h1: base16 = OFD_BASE_BX_DI;
      3'h2: base16 = OFD_BASE_BP_SI;
      3'h3: base16 = OFD_BASE_BP_DI;
      3'h4: base16 = OFD_BASE_SI;
      3'h5: base16 = OFD_BASE_DI;
      3'h6: base16 = OFD_BASE_BP;
      default: base16 = OFD_BASE_BX;
    endcase
  endfunction

  wire logic direct16;
  wire ofd_base_t base_a16;
  wire ofd_seg_t seg_a16;
  wire logic [2:0] disp_a16;
  wire logic bp_disp16;

  // Direct address or base choice
  assign direct16 = (form == `OFD_FORM_NODISP) && (rm == `OFD_RM16_DIRECT); // RL9
  assign base_a16 = direct16 ? OFD_BASE_NONE : base16(rm); // RL9 RL10
  // Only the lone base pointer with a displacement uses the stack segment
  assign bp_disp16 = (form != `OFD_FORM_NODISP) && (rm == `OFD_RM16_DIRECT); // RL10
  assign seg_a16 = bp_disp16 ? OFD_SEG_STACK : OFD_SEG_DATA; // RL9 RL10
  assign disp_a16 = direct16 ? 3'h2 :
                    (form == `OFD_FORM_DISP8) ? 3'h1 :
                    (form == `OFD_FORM_DISPW) ? 3'h2 : 3'h0; // RL10

  // ----------------------------------------
  // 32-bit addressing decode
  // ----------------------------------------
  wire logic sib32;
  wire logic direct32;
  wire ofd_base_t base_a32;
  wire ofd_seg_t seg_a32;
  wire logic [2:0] disp_a32;

  // Scaled-index and direct address detection
  assign sib32 = (rm == `OFD_RM32_SIB); // RL11
  assign direct32 = (form == `OFD_FORM_NODISP) && (rm == `OFD_RM32_DIRECT); // RL12
  assign base_a32 = sib32 ? OFD_BASE_SIB :
                    direct32 ? OFD_BASE_NONE : OFD_BASE_GPR32; // RL11 RL12
  // Segment after a scaled-index byte is resolved downstream
  assign seg_a32 = (!sib32 && !direct32 && rm == `OFD_RM32_DIRECT) ?
                   OFD_SEG_STACK : OFD_SEG_DATA; // RL12
  assign disp_a32 = direct32 ? 3'h4 :
                    (form == `OFD_FORM_DISP8) ? 3'h1 :
                    (form == `OFD_FORM_DISPW) ? 3'h4 : 3'h0; // RL12

  // ----------------------------------------
  // Register operand decode
  // ----------------------------------------
  wire ofd_regw_t regw;
  wire logic [2:0] regn;

  // Byte registers split low and high halves
  assign regw = (op_size == OFD_SZ8) ? (rm[2] ? OFD_RW_HIGH8 : OFD_RW_LOW8) :
                (op_size == OFD_SZ32) ? OFD_RW_32 : OFD_RW_16; // RL14 RL15
  assign regn = (op_size == OFD_SZ8) ? {1'b0, rm[1:0]} : rm; // RL14

  // ----------------------------------------
  // Immediate decode
  // ----------------------------------------
  wire logic [2:0] imm_len;
  wire logic [31:0] imm_value;

  // Length and extension of the immediate
  ofd_imm_decoder u_imm (
    .sext_bit_in(sext_bit_in),
    .op_size_in(op_size),
    .imm_raw_in(imm_raw_in),
    .imm_len_out(imm_len),
    .imm_value_out(imm_value)
  );

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  wire logic mem_next;
  wire logic sys_bad;

  // Memory operand and selector fault
  assign mem_next = has_modrm_in && !reg_form; // RL8
  assign sys_bad = sys_access && !sys_good; // RL7

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      is_mem_out <= 1'b0;
      is_reg_out <= 1'b0;
      need_sib_out <= 1'b0;
      disp_len_out <= 3'h0;
      base_out <= OFD_BASE_NONE;
      base_gpr_out <= 3'h0;
      seg_out <= OFD_SEG_DATA;
      reg_num_out <= 3'h0;
      reg_width_out <= OFD_RW_LOW8;
      op_size_out <= OFD_SZ8;
      imm_len_out <= `OFD_RST_LEN;
      imm_value_out <= `OFD_RST_IMM;
      sys_valid_out <= 1'b0;
      sys_reg_out <= 3'h0;
      invalid_out <= 1'b0;
    end else begin
      valid_out <= valid_in;
      is_mem_out <= valid_in && mem_next; // RL8
      is_reg_out <= valid_in && reg_form; // RL13
      need_sib_out <= valid_in && mem_next && addr32_in && sib32; // RL11
      disp_len_out <= !mem_next ? 3'h0 : addr32_in ? disp_a32 : disp_a16;
      base_out <= !mem_next ? OFD_BASE_NONE : addr32_in ? base_a32 : base_a16;
      base_gpr_out <= rm; // RL12
      seg_out <= !mem_next ? OFD_SEG_DATA : addr32_in ? seg_a32 : seg_a16;
      reg_num_out <= regn; // RL13
      reg_width_out <= regw; // RL13
      op_size_out <= op_size;
      imm_len_out <= imm_len;
      imm_value_out <= imm_value;
      sys_valid_out <= valid_in && sys_access && sys_good; // RL3
      sys_reg_out <= sys_good ? sys_sel_in : 3'h0; // RL7
      invalid_out <= valid_in && sys_bad; // RL7
    end
  end

endmodule

`default_nettype wire

// >>> dv/ofd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none

module ofd_fetch_model (
  input wire logic clk_in,
  input wire logic en_in,
  output logic [51:0] fetch_out
);
  // Fresh random fields just after each edge, quiet while disabled
  initial begin
    void'($urandom(26));
    fetch_out = '0;
    forever begin
      @(posedge clk_in);
      #1;
      fetch_out = en_in ? 52'({$urandom, $urandom}) : '0;
    end
  end
endmodule

`default_nettype wire

// >>> dv/ofd_operand_decoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module ofd_operand_decoder_monitor
  import ofd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire logic has_modrm_in,
  input wire logic addr32_in,
  input wire logic width_bit_in,
  input wire logic width_present_in,
  input wire logic sext_bit_in,
  input wire logic [7:0] modrm_in,
  input wire logic [31:0] imm_raw_in,
  input wire ofd_pkg::ofd_class_t sys_class_in,
  input wire logic [2:0] sys_sel_in,
  input wire logic is_mem_out,
  input wire logic is_reg_out,
  input wire logic need_sib_out,
  input wire logic [2:0] disp_len_out,
  input wire ofd_pkg::ofd_base_t base_out,
  input wire logic [2:0] imm_len_out,
  input wire logic [31:0] imm_value_out,
  input wire logic sys_valid_out,
  input wire logic [2:0] sys_reg_out,
  input wire logic invalid_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Byte operand and memory request helpers
  wire logic byte_op = width_present_in && !width_bit_in;
  wire logic mem_req = valid_in && has_modrm_in && modrm_in[7:6] != 2'h3;
  // Immediate sizing
  imm_sext_a: assert property (
    sext_bit_in && !byte_op |=> imm_len_out == 3'h1
      && imm_value_out == {{24{$past(imm_raw_in[7])}}, $past(imm_raw_in[7:0])})
    else $error("sign-extended immediate wrong");
  imm_byte_a: assert property (
    byte_op |=> imm_len_out == 3'h1 && imm_value_out == {24'h0, $past(imm_raw_in[7:0])})
    else $error("byte immediate wrong");
  // System register selector
  ctrl_gap_a: assert property (
    valid_in && sys_class_in == OFD_CLS_CTRL && sys_sel_in == 3'h1
      |=> invalid_out && !sys_valid_out)
    else $error("control selector 001 accepted");
  dbg_high_a: assert property (
    valid_in && sys_class_in == OFD_CLS_DBG && sys_sel_in[2:1] == 2'h3
      |=> sys_valid_out && sys_reg_out == $past(sys_sel_in))
    else $error("debug selector 11x refused");
  test_low_a: assert property (
    valid_in && sys_class_in == OFD_CLS_TEST && sys_sel_in < 3'h3
      |=> invalid_out && sys_reg_out == 3'h0)
    else $error("test selector below 011 accepted");
  // Addressing forms
  sib_need_a: assert property (
    mem_req && addr32_in && modrm_in[2:0] == 3'h4 |=> need_sib_out && base_out == OFD_BASE_SIB)
    else $error("scaled-index byte not expected");
  direct16_a: assert property (
    mem_req && !addr32_in && modrm_in[7:6] == 2'h0 && modrm_in[2:0] == 3'h6
      |=> disp_len_out == 3'h2 && base_out == OFD_BASE_NONE)
    else $error("direct 16-bit address wrong");
  reg_form_a: assert property (
    valid_in && has_modrm_in && modrm_in[7:6] == 2'h3 |=> is_reg_out && !is_mem_out)
    else $error("form 11 not a register operand");
endmodule

bind ofd_operand_decoder ofd_operand_decoder_monitor ofd_operand_decoder_monitor_inst (
  .clk_in, .rst_in, .valid_in, .has_modrm_in, .addr32_in, .width_bit_in, .width_present_in,
  .sext_bit_in, .modrm_in, .imm_raw_in, .sys_class_in, .sys_sel_in, .is_mem_out, .is_reg_out,
  .need_sib_out, .disp_len_out, .base_out, .imm_len_out, .imm_value_out, .sys_valid_out,
  .sys_reg_out, .invalid_out);

`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import ofd_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic en = 1'b0;
  logic [51:0] f;
  logic valid_in, has_modrm_in, addr32_in, op32_in, width_bit_in, width_present_in, sext_bit_in;
  logic [7:0] modrm_in;
  logic [31:0] imm_raw_in, imm_value_out, iv;
  logic [1:0] cls, fm;
  logic [2:0] sys_sel_in, disp_len_out, reg_num_out, imm_len_out, sys_reg_out, rm, base_gpr_out;
  logic valid_out, is_mem_out, is_reg_out, need_sib_out, sys_valid_out, invalid_out;
  ofd_base_t base_out;
  ofd_seg_t seg_out;
  ofd_regw_t reg_width_out;
  ofd_size_t op_size_out;
  int errors = 0, comparisons = 0, cycles = 0;
  int v, mem, sz, ok, bw, b, dl;
  assign {valid_in, has_modrm_in, addr32_in, op32_in, width_bit_in, width_present_in,
    sext_bit_in, modrm_in, imm_raw_in, cls, sys_sel_in} = f;

  ofd_fetch_model ofd_fetch_model_inst (.clk_in, .en_in(en), .fetch_out(f));
  ofd_operand_decoder ofd_operand_decoder_inst (.clk_in, .rst_in, .valid_in, .has_modrm_in,
    .addr32_in, .op32_in, .width_bit_in, .width_present_in, .sext_bit_in, .modrm_in,
    .imm_raw_in, .sys_class_in(ofd_class_t'(cls)), .sys_sel_in, .valid_out, .is_mem_out,
    .is_reg_out, .need_sib_out, .disp_len_out, .base_out, .base_gpr_out, .seg_out,
    .reg_num_out, .reg_width_out, .op_size_out, .imm_len_out, .imm_value_out,
    .sys_valid_out, .sys_reg_out, .invalid_out);

  // Clock and hang guard
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Reference decode of the inputs taken at the last edge
  task automatic decode(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #0.5;
      v = valid_in;
      fm = modrm_in[7:6];
      rm = modrm_in[2:0];
      mem = v && has_modrm_in && fm != 2'h3;
      bw = width_present_in && !width_bit_in;
      sz = bw ? 0 : op32_in ? 2 : 1;
      ok = ((cls == 2'h1 ? 8'h1d : cls == 2'h2 ? 8'hcf
        : cls == 2'h3 ? 8'hf8 : 8'h0) >> sys_sel_in) & 1;
      iv = sz == 0 ? {24'h0, imm_raw_in[7:0]}
        : sext_bit_in ? {{24{imm_raw_in[7]}}, imm_raw_in[7:0]}
        : sz == 1 ? {16'h0, imm_raw_in[15:0]} : imm_raw_in;
      b = addr32_in ? (rm == 3'h4 ? 10 : fm == 2'h0 && rm == 3'h5 ? 0 : 9)
        : (fm == 2'h0 && rm == 3'h6 ? 0 : rm + 1);
      dl = fm == 2'h1 ? 1 : fm == 2'h2 ? (addr32_in ? 4 : 2)
        : addr32_in ? (rm == 3'h5 ? 4 : 0) : (rm == 3'h6 ? 2 : 0);
      chk("valid", v, valid_out);
      chk("is_mem", mem, is_mem_out);
      chk("is_reg", v && has_modrm_in && fm == 2'h3, is_reg_out);
      chk("need_sib", mem && addr32_in && rm == 3'h4, need_sib_out);
      chk("op_size", sz, op_size_out);
      chk("imm_len", sz == 0 || sext_bit_in ? 1 : sz * 2, imm_len_out);
      chk("imm_value", iv, imm_value_out);
      chk("sys_valid", v & ok, sys_valid_out);
      chk("invalid", v && cls != 2'h0 && !ok, invalid_out);
      if (v & ok) chk("sys_reg", sys_sel_in, sys_reg_out);
      if (cls != 2'h0 && !ok) chk("sys_reg_bad", 0, sys_reg_out);
      if (!has_modrm_in || fm == 2'h3) begin
        chk("no_disp", 0, disp_len_out);
        chk("no_base", 0, base_out);
      end
      if (mem) begin
        chk("base", b, base_out);
        if (b == 9) chk("base_gpr", rm, base_gpr_out);
        chk("seg", fm != 2'h0 && rm == (addr32_in ? 3'h5 : 3'h6), seg_out);
        if (!(b == 10 && fm == 2'h0)) chk("disp", dl, disp_len_out);
      end
      if (v && has_modrm_in && fm == 2'h3) begin
        chk("reg_num", bw ? rm & 3'h3 : rm, reg_num_out);
        chk("reg_width", bw ? rm[2] : op32_in ? 3 : 2, reg_width_out);
      end
    end
  endtask

  // Reset, then random back-to-back decoding
  initial begin
    repeat (6) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    en = 1'b1;
    decode(2000);
    $display("Test random decode done");
    // Mid-run reset clears every output, then decoding resumes
    #0.5;
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #0.5;
    chk("reset_fields", 32'h0, {2'h0, valid_out, is_mem_out, is_reg_out, need_sib_out,
      disp_len_out, base_out, base_gpr_out, seg_out, reg_num_out, reg_width_out, op_size_out,
      imm_len_out, sys_valid_out, sys_reg_out, invalid_out});
    chk("reset_imm", 32'h0, imm_value_out);
    #0.5;
    rst_in = 1'b0;
    decode(500);
    $display("Test mid-run reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
